// ---- rtl/rpsel_pkg.sv ----
package rpsel_pkg;

    localparam int NUM_IO = 32;
    localparam int NUM_IN_ONLY = 12;
    localparam int NUM_PIN = 44;
    localparam int NUM_IN_FUNC = 37;
    localparam int NUM_OUT_SRC = 31;
    localparam int NUM_OUT_REG = 16;
    localparam int NUM_IN_REG = 19;
    localparam int SEL_W = 6;
    localparam int REG_W = 16;
    localparam int IDX_W = 5;
    localparam int FLD_LO_LSB = 0;
    localparam int FLD_HI_LSB = 8;
    localparam int LOCK_BIT = 6;

    typedef logic [SEL_W-1:0] rpsel_sel_t;
    typedef logic [NUM_IO-1:0][SEL_W-1:0] rpsel_osel_t;
    typedef logic [NUM_IN_FUNC-1:0][SEL_W-1:0] rpsel_isel_t;

    localparam rpsel_sel_t OUT_NULL = 6'h00;
    localparam rpsel_sel_t IN_TIED = 6'h3F;
    localparam logic [7:0] KEY_FIRST = 8'h46;
    localparam logic [7:0] KEY_SECOND = 8'h57;
    localparam logic FUSE_DEFAULT = 1'h1;
    localparam logic [NUM_IO-1:0] IO_IMPL_ALL = 32'hFFFFFFFF;
    localparam logic [NUM_IN_ONLY-1:0] IN_IMPL_ALL = 12'hFFF;

    typedef enum logic [1:0] {
        UNL_IDLE = 2'b00,
        UNL_KEY1 = 2'b01,
        UNL_ARMED = 2'b10
    } rpsel_unl_e;

    typedef enum logic [5:0] {
        OUT_NONE = 6'h00, OUT_CMP_ONE = 6'h01, OUT_CMP_TWO = 6'h02, OUT_SER1_TX = 6'h03,
        OUT_SER1_RTS = 6'h04, OUT_SER2_TX = 6'h05, OUT_SER2_RTS = 6'h06, OUT_SPI1_DAT = 6'h07,
        OUT_SPI1_CLK = 6'h08, OUT_SPI1_SEL = 6'h09, OUT_SPI2_DAT = 6'h0A, OUT_SPI2_CLK = 6'h0B,
        OUT_SPI2_SEL = 6'h0C, OUT_OCMP_ONE = 6'h0D, OUT_OCMP_TWO = 6'h0E, OUT_OCMP_THR = 6'h0F,
        OUT_CCP_FOUR = 6'h10, OUT_CCP_FIVE = 6'h11, OUT_CCP_SIX = 6'h12, OUT_SER3_TX = 6'h13,
        OUT_SER3_RTS = 6'h14, OUT_SER4_TX = 6'h15, OUT_SER4_RTS = 6'h16, OUT_SPI3_DAT = 6'h17,
        OUT_SPI3_CLK = 6'h18, OUT_SPI3_SEL = 6'h19, OUT_CMP_THREE = 6'h1A, OUT_CCP_SEVEN = 6'h1B,
        OUT_REF_CLK = 6'h1C, OUT_LCELL_ONE = 6'h1D, OUT_LCELL_TWO = 6'h1E, OUT_RTC = 6'h1F
    } rpsel_out_code_e;

    function automatic rpsel_sel_t rpsel_field(input logic [REG_W-1:0] data, input int f);
        return (f == 0) ? data[FLD_LO_LSB +: SEL_W] : data[FLD_HI_LSB +: SEL_W];
    endfunction

    function automatic logic [REG_W-1:0] rpsel_pack(input rpsel_sel_t hi, input rpsel_sel_t lo);
        logic [REG_W-1:0] r;
        r = '0;
        r[FLD_HI_LSB +: SEL_W] = hi;
        r[FLD_LO_LSB +: SEL_W] = lo;
        return r;
    endfunction

endpackage

// ---- rtl/rpsel_map_if.sv ----
`timescale 1ns/1ps
interface rpsel_map_if;
    rpsel_pkg::rpsel_osel_t out_sel;
    rpsel_pkg::rpsel_isel_t in_sel;
    logic [rpsel_pkg::NUM_PIN-1:0] pin_in;
    logic [rpsel_pkg::NUM_PIN-1:0] pin_ok;
    logic [rpsel_pkg::NUM_OUT_SRC-1:0] periph_out;
    logic [rpsel_pkg::NUM_IN_FUNC-1:0] periph_in;
    logic [rpsel_pkg::NUM_IO-1:0] remap_out;
    logic [rpsel_pkg::NUM_IO-1:0] remap_act;
    modport ctrl (output out_sel, in_sel, pin_in, pin_ok, periph_out,
                  input periph_in, remap_out, remap_act);
    modport omux (input out_sel, periph_out, output remap_out, remap_act);
    modport imux (input in_sel, pin_in, pin_ok, output periph_in);
endinterface

// ---- rtl/rpsel_out_mux.sv ----
`timescale 1ns/1ps
module rpsel_out_mux (
    input wire logic clk,
    input wire logic rst_n,
    rpsel_map_if.omux map
);
    ////////////////////////////////////////////////////////////////////////////////
    // Codes above the table fall back to null rather than pick an undefined source.
    always_comb begin
        for (int i = 0; i < rpsel_pkg::NUM_IO; i++) begin
            map.remap_act[i] = 1'b0;
            map.remap_out[i] = 1'b0;
            if (map.out_sel[i] != rpsel_pkg::OUT_NULL
                    && map.out_sel[i] <= rpsel_pkg::OUT_RTC) begin
                map.remap_act[i] = 1'b1;
                // One source may feed many pins; one field per pin forbids two on one.
                map.remap_out[i] = map.periph_out[5'(map.out_sel[i] - 6'h01)];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    for (genvar g = 0; g < rpsel_pkg::NUM_IO; g++) begin : g_chk
        null_out_a: assert property (@(posedge clk) disable iff (!rst_n)
            (map.out_sel[g] == rpsel_pkg::OUT_NULL) |-> !map.remap_act[g])
            else $error("null code drives a pin");
    end
endmodule // rpsel_out_mux

// ---- rtl/rpsel_in_mux.sv ----
`timescale 1ns/1ps
module rpsel_in_mux (
    input wire logic clk,
    input wire logic rst_n,
    rpsel_map_if.imux map
);
    logic [rpsel_pkg::NUM_IN_FUNC-1:0] sel_ok;

    ////////////////////////////////////////////////////////////////////////////////
    // Each input owns one field, so two pins can never contend for one input.
    always_comb begin
        for (int k = 0; k < rpsel_pkg::NUM_IN_FUNC; k++) begin
            sel_ok[k] = (map.in_sel[k] < 6'(rpsel_pkg::NUM_PIN))
                && map.pin_ok[map.in_sel[k]];
            map.periph_in[k] = sel_ok[k] ? map.pin_in[map.in_sel[k]] : 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    for (genvar g = 0; g < rpsel_pkg::NUM_IN_FUNC; g++) begin : g_chk
        invalid_in_a: assert property (@(posedge clk) disable iff (!rst_n)
            !sel_ok[g] |-> !map.periph_in[g])
            else $error("invalid select feeds an input");
        in_route_a: assert property (@(posedge clk) disable iff (!rst_n)
            sel_ok[g] |-> map.periph_in[g] == map.pin_in[map.in_sel[g]])
            else $error("input not taken from selected pin");
    end
endmodule // rpsel_in_mux

// ---- rtl/rpsel_top.sv ----
`timescale 1ns/1ps
// Operation
// - Output select registers hold two 6-bit pin fields choosing the driving source.
// - Null output code leaves the pin disconnected from every remappable source.
// - Codes 1 to 15 pick comparators, serial ports one/two, SPI one/two, compares.
// - Codes 16 to 31 pick capture-compare, serial three/four, SPI three, clocks, cells.
// - No contention: one source per input, one source per pin; nothing else locked out.
// - One pin may feed many inputs; one source may drive many pins.
// - Input select naming an absent pin is invalid; that input sees nothing.
// - Output fields of absent pins are unimplemented; writes to them are ignored.
// - Large variant has 32 remappable I/O and 12 input-only pins; smaller fewer.
// - Writes while locked complete quietly but leave the mapping unchanged.
// - Lock bit six of oscillator control gates all mapping register writes.
// - Lock changes only after writing 46h then 57h, then one lock write.
// - Lock holds its state until changed again; it never relocks by itself.
// - Shadow copies watch every mapping field; a mismatch raises a mismatch reset.
// - With single-session fuse set, lock cannot clear once set until reset.
// - Single-session fuse defaults set; cleared fuse allows unlimited unlock sessions.
// - Reset loads input fields with all ones and output fields with zeros.
// - Lock resets unlocked, so mapping is writable straight after reset.
// - Mapping enables no peripheral and leaves pin direction and setup untouched.
// - Remapping never overrides analog pins nor turns them into digital I/O.
// - Each peripheral input has a 6-bit field naming its source pin.
// - Remapped output beats port functions; dedicated outputs beat remapped output.
module rpsel_top #(
    parameter logic [rpsel_pkg::NUM_IO-1:0] IO_IMPL = rpsel_pkg::IO_IMPL_ALL,
    parameter logic [rpsel_pkg::NUM_IN_ONLY-1:0] IN_IMPL = rpsel_pkg::IN_IMPL_ALL
) (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic CFG_WR,
    input wire logic CFG_IS_IN,
    input wire logic [rpsel_pkg::IDX_W-1:0] CFG_IDX,
    input wire logic [rpsel_pkg::REG_W-1:0] CFG_WDATA,
    output logic [rpsel_pkg::REG_W-1:0] CFG_RDATA,
    input wire logic OSC_WR,
    input wire logic [7:0] OSC_WDATA,
    output logic REMAP_LOCK,
    input wire logic SINGLE_SESSION_FUSE,
    output logic CFG_MISMATCH_RST,
    input wire logic [rpsel_pkg::NUM_OUT_SRC-1:0] PERIPH_OUT,
    output logic [rpsel_pkg::NUM_IN_FUNC-1:0] PERIPH_IN,
    input wire logic [rpsel_pkg::NUM_PIN-1:0] PIN_IN,
    input wire logic [rpsel_pkg::NUM_PIN-1:0] ANALOG_EN,
    input wire logic [rpsel_pkg::NUM_IO-1:0] PORT_OUT,
    input wire logic [rpsel_pkg::NUM_IO-1:0] PORT_OE,
    input wire logic [rpsel_pkg::NUM_IO-1:0] DEDIC_EN,
    input wire logic [rpsel_pkg::NUM_IO-1:0] DEDIC_OUT,
    input wire logic [rpsel_pkg::NUM_IO-1:0] DEDIC_OE,
    output logic [rpsel_pkg::NUM_IO-1:0] PIN_OUT,
    output logic [rpsel_pkg::NUM_IO-1:0] PIN_OE
);

    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [rpsel_pkg::NUM_PIN-1:0] pin_s1;
        logic [rpsel_pkg::NUM_PIN-1:0] pin_s2;
        logic fuse_s1;
        logic fuse_s2;
        rpsel_pkg::rpsel_osel_t out_sel;
        rpsel_pkg::rpsel_isel_t in_sel;
        rpsel_pkg::rpsel_osel_t out_shd;
        rpsel_pkg::rpsel_isel_t in_shd;
        logic lock;
        logic set_once;
        rpsel_pkg::rpsel_unl_e unl;
        logic [rpsel_pkg::REG_W-1:0] rdata;
        logic mismatch;
        logic [rpsel_pkg::NUM_IO-1:0] pin_out;
        logic [rpsel_pkg::NUM_IO-1:0] pin_oe;
        logic [rpsel_pkg::NUM_IN_FUNC-1:0] periph_in;
    } rpsel_top_s;

    // The fuse synchroniser starts at its unprogrammed value so one session applies at once.
    localparam rpsel_top_s RST_STATE = '{
        pin_s1: '0,
        pin_s2: '0,
        fuse_s1: rpsel_pkg::FUSE_DEFAULT,
        fuse_s2: rpsel_pkg::FUSE_DEFAULT,
        out_sel: '0,
        in_sel: '1,
        out_shd: '0,
        in_shd: '1,
        lock: 1'b0,
        set_once: 1'b0,
        unl: rpsel_pkg::UNL_IDLE,
        rdata: '0,
        mismatch: 1'b0,
        pin_out: '0,
        pin_oe: '0,
        periph_in: '0
    };

    rpsel_top_s q;
    rpsel_top_s d;
    logic wr_ok;
    logic lock_hold;
    logic armed_wr;

    rpsel_map_if map ();

    ////////////////////////////////////////////////////////////////////////////////
    // Analog pins present a zero to every remapped input.
    assign map.out_sel = q.out_sel;
    assign map.in_sel = q.in_sel;
    assign map.pin_in = q.pin_s2 & ~ANALOG_EN;
    assign map.pin_ok = {IN_IMPL, IO_IMPL};
    assign map.periph_out = PERIPH_OUT;

    rpsel_out_mux u_out_mux (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .map(map.omux)
    );

    rpsel_in_mux u_in_mux (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .map(map.imux)
    );

    ////////////////////////////////////////////////////////////////////////////////
    assign wr_ok = CFG_WR && !q.lock;
    assign lock_hold = q.fuse_s2 && q.set_once;
    assign armed_wr = (q.unl == rpsel_pkg::UNL_ARMED) && OSC_WR;

    always_comb begin
        int idx;
        logic [1:0][rpsel_pkg::SEL_W-1:0] rd;
        idx = 0;
        rd = '0;
        d = q;
        d.pin_s1 = PIN_IN;
        d.pin_s2 = q.pin_s1;
        d.fuse_s1 = SINGLE_SESSION_FUSE;
        d.fuse_s2 = q.fuse_s1;

        // Register access; the shadow copy is only ever written by this path.
        for (int f = 0; f < 2; f++) begin
            idx = 2 * int'(CFG_IDX) + f;
            if (CFG_IS_IN && idx < rpsel_pkg::NUM_IN_FUNC) begin
                rd[f] = q.in_sel[idx];
                if (wr_ok) begin
                    d.in_sel[idx] = rpsel_pkg::rpsel_field(CFG_WDATA, f);
                    d.in_shd[idx] = rpsel_pkg::rpsel_field(CFG_WDATA, f);
                end
            end else if (!CFG_IS_IN && idx < rpsel_pkg::NUM_IO) begin
                rd[f] = q.out_sel[idx];
                if (wr_ok && IO_IMPL[idx]) begin
                    d.out_sel[idx] = rpsel_pkg::rpsel_field(CFG_WDATA, f);
                    d.out_shd[idx] = rpsel_pkg::rpsel_field(CFG_WDATA, f);
                end
            end
        end
        d.rdata = rpsel_pkg::rpsel_pack(rd[1], rd[0]);

        // Key writes must be back to back accesses; idle cycles between them are harmless.
        unique case (q.unl)
            rpsel_pkg::UNL_IDLE: begin
                if (OSC_WR && OSC_WDATA == rpsel_pkg::KEY_FIRST) begin
                    d.unl = rpsel_pkg::UNL_KEY1;
                end
            end
            rpsel_pkg::UNL_KEY1: begin
                if (OSC_WR && OSC_WDATA == rpsel_pkg::KEY_SECOND) begin
                    d.unl = rpsel_pkg::UNL_ARMED;
                end else if (OSC_WR && OSC_WDATA == rpsel_pkg::KEY_FIRST) begin
                    d.unl = rpsel_pkg::UNL_KEY1;
                end else if (OSC_WR || CFG_WR) begin
                    d.unl = rpsel_pkg::UNL_IDLE;
                end
            end
            rpsel_pkg::UNL_ARMED: begin
                if (OSC_WR) begin
                    d.unl = rpsel_pkg::UNL_IDLE;
                    if (!(lock_hold && !OSC_WDATA[rpsel_pkg::LOCK_BIT])) begin
                        d.lock = OSC_WDATA[rpsel_pkg::LOCK_BIT];
                    end
                end else if (CFG_WR) begin
                    d.unl = rpsel_pkg::UNL_IDLE;
                end
            end
            default: begin
                d.unl = rpsel_pkg::UNL_IDLE;
            end
        endcase
        if (d.lock) begin
            d.set_once = 1'b1;
        end

        // Held for as long as the stored map and its shadow disagree.
        d.mismatch = (q.out_sel != q.out_shd) || (q.in_sel != q.in_shd);

        // Direction always comes from the port or a dedicated function, never the mapping.
        for (int p = 0; p < rpsel_pkg::NUM_IO; p++) begin
            if (DEDIC_EN[p]) begin
                d.pin_out[p] = DEDIC_OUT[p];
                d.pin_oe[p] = DEDIC_OE[p];
            end else begin
                d.pin_out[p] = map.remap_act[p] ? map.remap_out[p] : PORT_OUT[p];
                d.pin_oe[p] = PORT_OE[p] && !ANALOG_EN[p];
            end
        end
        d.periph_in = map.periph_in;
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            q <= RST_STATE;
        end else begin
            q <= d;
        end
    end

    assign CFG_RDATA = q.rdata;
    assign REMAP_LOCK = q.lock;
    assign CFG_MISMATCH_RST = q.mismatch;
    assign PIN_OUT = q.pin_out;
    assign PIN_OE = q.pin_oe;
    assign PERIPH_IN = q.periph_in;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);

    sequence key_first_s;
        OSC_WR && !CFG_WR && OSC_WDATA == rpsel_pkg::KEY_FIRST
            && q.unl != rpsel_pkg::UNL_ARMED;
    endsequence

    sequence key_second_s;
        OSC_WR && !CFG_WR && OSC_WDATA == rpsel_pkg::KEY_SECOND;
    endsequence

    sequence unlock_keys_s;
        key_first_s ##1 key_second_s;
    endsequence

    property lock_set_p;
        unlock_keys_s ##1 (OSC_WR && OSC_WDATA[rpsel_pkg::LOCK_BIT]) |=> REMAP_LOCK;
    endproperty

    property lock_clear_p;
        unlock_keys_s ##1 (OSC_WR && !OSC_WDATA[rpsel_pkg::LOCK_BIT] && !lock_hold)
            |=> !REMAP_LOCK;
    endproperty

    lock_set_a: assert property (lock_set_p)
        else $error("lock not set after key sequence");

    lock_clear_a: assert property (lock_clear_p)
        else $error("lock not cleared after key sequence");

    lock_hold_a: assert property ($changed(REMAP_LOCK) |-> $past(armed_wr))
        else $error("lock changed outside the armed write");

    fuse_hold_a: assert property ((lock_hold && REMAP_LOCK) |=> REMAP_LOCK[*3])
        else $error("lock cleared in single session mode");

    locked_write_a: assert property ((CFG_WR && REMAP_LOCK)
        |=> $stable(q.out_sel) && $stable(q.in_sel))
        else $error("mapping changed while locked");

    open_write_a: assert property ((CFG_WR && !REMAP_LOCK && !CFG_IS_IN
        && CFG_IDX == 5'h00 && IO_IMPL[0])
        |=> q.out_sel[0] == $past(CFG_WDATA[rpsel_pkg::SEL_W-1:0]))
        else $error("unlocked write not stored");

    seq_abort_a: assert property ((q.unl == rpsel_pkg::UNL_KEY1 && CFG_WR && !OSC_WR)
        |=> q.unl == rpsel_pkg::UNL_IDLE ##1 $stable(REMAP_LOCK))
        else $error("interrupted key sequence not aborted");

    mismatch_a: assert property ((q.out_sel != q.out_shd || q.in_sel != q.in_shd)
        |=> CFG_MISMATCH_RST)
        else $error("shadow mismatch not flagged");

    // Every pin is watched, so whichever pin a test makes dedicated or analog is covered.
    for (genvar g = 0; g < rpsel_pkg::NUM_IO; g++) begin : g_pin
        dedic_prio_a: assert property (DEDIC_EN[g]
            |=> PIN_OUT[g] == $past(DEDIC_OUT[g]))
            else $error("dedicated output lost priority");
        analog_off_a: assert property ((ANALOG_EN[g] && !DEDIC_EN[g])
            |=> !PIN_OE[g])
            else $error("analog pin driven as digital");
    end

    for (genvar g = 0; g < rpsel_pkg::NUM_IO; g++) begin : g_unimpl
        if (!IO_IMPL[g]) begin : g_off
            unimpl_field_a: assert property (q.out_sel[g] == rpsel_pkg::OUT_NULL)
                else $error("absent pin field took a write");
        end
    end

endmodule // rpsel_top

// ---- tb/rpsel_far_model.sv ----
`timescale 1ns/1ps
// Peripherals and pads; both change only just after a clock edge, as real logic does.
module rpsel_far_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [30:0] want_out,
    input wire logic [43:0] want_pin,
    output logic [30:0] periph_out,
    output logic [43:0] pin_in
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            periph_out <= 31'h00000000;
            pin_in <= 44'h00000000000;
        end else begin
            periph_out <= want_out;
            pin_in <= want_pin;
        end
    end
endmodule // rpsel_far_model

// ---- tb/rpsel_top_tb.sv ----
`timescale 1ns/1ps
module rpsel_top_tb;
    logic sys_clk = 1'h0;
    logic rst_n = 1'h0;
    logic cfg_wr = 1'h0;
    logic cfg_is_in = 1'h0;
    logic [4:0] cfg_idx = 5'h00;
    logic [15:0] cfg_wdata = 16'h0000;
    logic [15:0] cfg_rdata;
    logic osc_wr = 1'h0;
    logic [7:0] osc_wdata = 8'h00;
    logic remap_lock;
    logic fuse = 1'h1;
    logic mism;
    logic [30:0] periph_out;
    logic [30:0] want_out = 31'h00000000;
    logic [36:0] periph_in;
    logic [43:0] pin_in;
    logic [43:0] want_pin = 44'h00000000000;
    logic [43:0] analog_en = 44'h00000000000;
    logic [31:0] port_out = 32'h00000000;
    logic [31:0] port_oe = 32'h00000000;
    logic [31:0] dedic_en = 32'h00000000;
    logic [31:0] dedic_out = 32'h00000000;
    logic [31:0] dedic_oe = 32'h00000000;
    logic [31:0] pin_out;
    logic [31:0] pin_oe;
    int bad_count = 0;
    int comparisons = 0;
    int c;

    always #10 sys_clk = ~sys_clk;

    // The 29-pin variant is used so that absent output fields are reachable.
    rpsel_top #(.IO_IMPL(32'h7FFF7FDF), .IN_IMPL(12'hFFF)) u_rpsel_top (
        .SYS_CLK(sys_clk),
        .RST_N(rst_n),
        .CFG_WR(cfg_wr),
        .CFG_IS_IN(cfg_is_in),
        .CFG_IDX(cfg_idx),
        .CFG_WDATA(cfg_wdata),
        .CFG_RDATA(cfg_rdata),
        .OSC_WR(osc_wr),
        .OSC_WDATA(osc_wdata),
        .REMAP_LOCK(remap_lock),
        .SINGLE_SESSION_FUSE(fuse),
        .CFG_MISMATCH_RST(mism),
        .PERIPH_OUT(periph_out),
        .PERIPH_IN(periph_in),
        .PIN_IN(pin_in),
        .ANALOG_EN(analog_en),
        .PORT_OUT(port_out),
        .PORT_OE(port_oe),
        .DEDIC_EN(dedic_en),
        .DEDIC_OUT(dedic_out),
        .DEDIC_OE(dedic_oe),
        .PIN_OUT(pin_out),
        .PIN_OE(pin_oe)
    );

    rpsel_far_model u_rpsel_far_model (
        .clk(sys_clk),
        .rst_n(rst_n),
        .want_out(want_out),
        .want_pin(want_pin),
        .periph_out(periph_out),
        .pin_in(pin_in)
    );

    ////////////////////////////////////////
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d.", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk_reg(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            $display("FAIL %s expected %b seen %b", what, exp, got);
            bad_count++;
        end
    endtask

    task automatic cfg_write(input logic is_in, input logic [4:0] idx, input logic [15:0] d);
        @(posedge sys_clk);
        cfg_wr <= 1'h1;
        cfg_is_in <= is_in;
        cfg_idx <= idx;
        cfg_wdata <= d;
        @(posedge sys_clk);
        cfg_wr <= 1'h0;
    endtask

    task automatic rd_reg(input logic is_in, input logic [4:0] idx, input logic [15:0] exp);
        @(posedge sys_clk);
        cfg_is_in <= is_in;
        cfg_idx <= idx;
        repeat (3) @(posedge sys_clk);
        #1;
        chk_reg("readback", exp, cfg_rdata);
    endtask

    task automatic osc_write(input logic [7:0] d);
        @(posedge sys_clk);
        osc_wr <= 1'h1;
        osc_wdata <= d;
        @(posedge sys_clk);
        osc_wr <= 1'h0;
    endtask

    task automatic settle();
        repeat (6) @(posedge sys_clk);
        #1;
    endtask

    // Keys go out back to back with nothing in between.
    task automatic lock_seq(input logic [7:0] last);
        @(posedge sys_clk);
        osc_wr <= 1'h1;
        osc_wdata <= 8'h46;
        @(posedge sys_clk);
        osc_wdata <= 8'h57;
        @(posedge sys_clk);
        osc_wdata <= last;
        @(posedge sys_clk);
        osc_wr <= 1'h0;
        settle();
    endtask

    ////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        complete_run();
    end

    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'h1;
        rd_reg(1'h0, 5'h00, 16'h0000);
        rd_reg(1'h1, 5'h00, 16'h3F3F);
        chk_bit("lock after reset", 1'h0, remap_lock);
        cfg_write(1'h0, 5'h01, 16'h0403);
        rd_reg(1'h0, 5'h01, 16'h0403);
        want_out <= 31'h00000004;
        settle();
        chk_bit("pin2", 1'h1, pin_out[2]);
        chk_bit("pin3", 1'h0, pin_out[3]);
        for (c = 1; c < 32; c++) begin
            cfg_write(1'h0, 5'h00, {10'h000, c[5:0]});
            want_out <= 31'h00000001 << (c - 1);
            settle();
            chk_bit("code source", 1'h1, pin_out[0]);
            want_out <= ~(31'h00000001 << (c - 1));
            settle();
            chk_bit("code others", 1'h0, pin_out[0]);
        end
        @(posedge sys_clk);
        port_out <= 32'h00000005;
        port_oe <= 32'h00000001;
        dedic_en <= 32'h00000002;
        dedic_out <= 32'h00000002;
        dedic_oe <= 32'h00000002;
        want_out <= 31'h00000000;
        cfg_write(1'h0, 5'h00, 16'h0100);
        settle();
        chk_bit("null pin", 1'h1, pin_out[0]);
        chk_bit("remap over port", 1'h0, pin_out[2]);
        chk_bit("dedicated", 1'h1, pin_out[1]);
        chk_bit("dedicated oe", 1'h1, pin_oe[1]);
        chk_bit("oe untouched", 1'h0, pin_oe[2]);
        chk_bit("port oe", 1'h1, pin_oe[0]);
        cfg_write(1'h0, 5'h03, 16'h0505);
        want_out <= 31'h00000010;
        settle();
        chk_bit("fanout pin6", 1'h1, pin_out[6]);
        chk_bit("fanout pin7", 1'h1, pin_out[7]);
        cfg_write(1'h0, 5'h02, 16'h0505);
        rd_reg(1'h0, 5'h02, 16'h0005);
        cfg_write(1'h1, 5'h00, 16'h0707);
        cfg_write(1'h1, 5'h01, 16'h2C2B);
        want_pin <= 44'hFFFFFFFFFFF;
        settle();
        chk_bit("fanin in0", 1'h1, periph_in[0]);
        chk_bit("fanin in1", 1'h1, periph_in[1]);
        chk_bit("input pin 43", 1'h1, periph_in[2]);
        chk_bit("absent pin", 1'h0, periph_in[3]);
        chk_bit("tied input", 1'h0, periph_in[4]);
        @(posedge sys_clk);
        analog_en <= 44'h00000000080;
        port_oe <= 32'h00000081;
        settle();
        chk_bit("analog pin", 1'h0, periph_in[0]);
        chk_bit("analog oe", 1'h0, pin_oe[7]);
        // Lock once setup is done, as software is advised to.
        lock_seq(8'h40);
        chk_bit("lock set", 1'h1, remap_lock);
        cfg_write(1'h0, 5'h03, 16'h0101);
        rd_reg(1'h0, 5'h03, 16'h0505);
        lock_seq(8'h00);
        chk_bit("one session", 1'h1, remap_lock);
        @(posedge sys_clk);
        rst_n <= 1'h0;
        fuse <= 1'h0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'h1;
        settle();
        chk_bit("lock after reset", 1'h0, remap_lock);
        rd_reg(1'h0, 5'h03, 16'h0000);
        lock_seq(8'h40);
        chk_bit("lock again", 1'h1, remap_lock);
        lock_seq(8'h00);
        chk_bit("lock cleared", 1'h0, remap_lock);
        cfg_write(1'h0, 5'h03, 16'h0101);
        cfg_write(1'h0, 5'h04, 16'h0202);
        rd_reg(1'h0, 5'h03, 16'h0101);
        rd_reg(1'h0, 5'h04, 16'h0202);
        osc_write(8'h46);
        cfg_write(1'h0, 5'h03, 16'h0303);
        osc_write(8'h57);
        osc_write(8'h40);
        settle();
        chk_bit("aborted keys", 1'h0, remap_lock);
        rd_reg(1'h0, 5'h03, 16'h0303);
        chk_bit("mismatch", 1'h0, mism);
        complete_run();
    end
endmodule // rpsel_top_tb
